// ===== core/lbp_burst_precharge.sv
// Purpose: Burst, terminate, mask and precharge sequencing of the device
// Assumes: Command bus halves arrive as rising/falling words on i_ck
// Notes:   Write pairs cross to i_clk by toggle; errors are test flags
//
// Summary of operation
// [R1] Write after read waits read data plus turnaround
// [R2] Seamless reads every BL/2 clocks accepted
// [R3] Read interrupt only for BL8/16, even, tCCD
// [R4] Read interrupted only by read or terminate
// [R5] Auto-precharge bursts are never interrupted
// [R6] Interrupted burst length is twice the gap
// [R7] Write decode and start column from bus
// [R8] Write data arrives WL clocks after command
// [R9] Write data captured until burst complete
// [R10] Read after write waits WL+1+BL/2+tWTR
// [R11] Seamless writes every BL/2 clocks accepted
// [R12] Write interrupt only BL8/16, even, by write
// [R13] Burst terminate decode on command bus
// [R14] Terminate only within active burst window
// [R15] Terminate on even gap, length twice gap
// [R16] Terminate ends output RL or WL later
// [R17] No second terminate before next access
// [R18] Per byte mask blocks that byte write
// [R19] Precharge decode, all-bank flag or one bank
// [R20] Bank ready after tRPab or tRPpb
// [R21] Read to precharge at least BL/2
// [R22] tRTP counted from BL/2-2 after read
// [R23] Read decode with CA2 high
// [R24] Bank state kept, spacing breaks flagged
`default_nettype none

module lbp_burst_precharge (
    // System clock domain
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // Link from the memory controller
    input  wire logic                 i_ck,
    input  wire logic                 i_cs_n,
    input  wire logic [9:0]           i_ca_r,
    input  wire logic [9:0]           i_ca_f,
    input  wire logic [31:0]          i_dq_r,
    input  wire logic [31:0]          i_dq_f,
    input  wire logic [3:0]           i_dm_r,
    input  wire logic [3:0]           i_dm_f,
    input  wire logic [1:0]           i_bl_sel,
    // Link side status
    output logic                      o_rd_en,
    // System side results
    output logic                      o_wr_valid,
    output lbp_pkg::lbp_wr_pair_s     o_wr_pair,
    output logic                      o_proto_err,
    output logic [7:0]                o_bank_open
);
    localparam int A_RL1 = lbp_pkg::RL + 1;
    localparam int A_WL1 = lbp_pkg::WL + 1;
    // Link reset release synchroniser
    logic                        lrst_a_q;
    logic                        lrst_n_q;
    always_ff @(posedge i_ck or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lrst_a_q <= 1'b0;
            lrst_n_q <= 1'b0;
        end else begin
            lrst_a_q <= 1'b1;
            lrst_n_q <= lrst_a_q;
        end
    end
    // Command decode
    logic                        is_cmd;
    logic                        rd_cmd;
    logic                        wr_cmd;
    logic                        bst_cmd;
    logic                        pre_cmd;
    logic                        act_cmd;
    logic                        all_bank_flag;
    logic [2:0]                  cmd_bank;
    lbp_pkg::lbp_addr_s          cmd_addr;
    assign is_cmd  = !i_cs_n && i_ca_r[lbp_pkg::CA_SEL0];
    assign rd_cmd  = is_cmd && !i_ca_r[lbp_pkg::CA_SEL1]
                     && i_ca_r[lbp_pkg::CA_SEL2];                    // R23
    assign wr_cmd  = is_cmd && !i_ca_r[lbp_pkg::CA_SEL1]
                     && !i_ca_r[lbp_pkg::CA_SEL2];                   // R7
    assign bst_cmd = is_cmd && i_ca_r[lbp_pkg::CA_SEL1]
                     && !i_ca_r[lbp_pkg::CA_SEL2]
                     && !i_ca_r[lbp_pkg::CA_SEL3];                   // R13
    assign pre_cmd = is_cmd && i_ca_r[lbp_pkg::CA_SEL1]
                     && !i_ca_r[lbp_pkg::CA_SEL2]
                     && i_ca_r[lbp_pkg::CA_SEL3];                    // R19
    assign act_cmd = !i_cs_n && !i_ca_r[lbp_pkg::CA_SEL0]
                     && i_ca_r[lbp_pkg::CA_SEL1];
    assign all_bank_flag = i_ca_r[lbp_pkg::CA_ALLBK];                // R19
    assign cmd_bank = i_ca_r[lbp_pkg::CA_BANK_L +: 3];
    assign cmd_addr.bank = cmd_bank;
    assign cmd_addr.col  = {i_ca_f[9:1], i_ca_r[6:5], 1'b0};         // R7
    // Burst tracking
    lbp_pkg::lbp_burst_e         burst_q;
    logic [5:0]                  gap_q;
    logic [3:0]                  half_q;
    logic                        bst_done_q;
    logic                        ap_q;
    logic [2:0]                  last_bank_q;
    logic [3:0]                  bl_half;
    logic                        active;
    assign bl_half = 4'h2 << i_bl_sel;
    assign active  = (burst_q != lbp_pkg::B_IDLE)
                     && ({2'h0, gap_q} < {4'h0, half_q});
    always_ff @(posedge i_ck or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            burst_q     <= lbp_pkg::B_IDLE;
            gap_q       <= lbp_pkg::GAP_RST;
            half_q      <= 4'h0;
            bst_done_q  <= 1'b0;
            ap_q        <= 1'b0;
            last_bank_q <= 3'h0;
        end else begin
            if (gap_q != lbp_pkg::GAP_RST) begin
                gap_q <= gap_q + 6'h1;
            end
            if (rd_cmd || wr_cmd) begin
                burst_q     <= rd_cmd ? lbp_pkg::B_RD : lbp_pkg::B_WR;
                gap_q       <= 6'h1;
                half_q      <= bl_half;
                bst_done_q  <= 1'b0;
                ap_q        <= i_ca_f[lbp_pkg::CA_AP];
                last_bank_q <= cmd_bank;
            end else if (bst_cmd && active && !bst_done_q) begin
                half_q     <= gap_q[3:0];                             // R15
                bst_done_q <= 1'b1;
            end
        end
    end
    // Spacing thresholds from the latest burst's effective length
    logic [6:0]                  rtw_min;
    logic [6:0]                  wtr_min;
    logic [6:0]                  rtp_min;
    logic [6:0]                  gap7;
    logic                        bl4;
    logic                        intr_bad;
    assign gap7    = {1'b0, gap_q};
    assign rtw_min = 7'(lbp_pkg::RL + lbp_pkg::RU_DQSCK + 1 - lbp_pkg::WL)
                     + {3'h0, half_q};                               // R1
    assign wtr_min = 7'(lbp_pkg::WL + 1 + lbp_pkg::RU_WTR)
                     + {3'h0, half_q};                               // R10
    assign rtp_min = 7'(lbp_pkg::RTP_EXTRA) + {3'h0, half_q};        // R22
    assign bl4     = (i_bl_sel == lbp_pkg::BL_SEL_4);
    assign intr_bad = active && (bl4 || gap_q[0] || ap_q
                      || gap7 < 7'(lbp_pkg::TCCD));                  // R3 R5 R12
    // Bank state and precharge timers
    logic [7:0]                  open_q;
    logic [7:0]                  rp_busy;
    logic [7:0]                  pre_hit;
    genvar gb;
    generate
        for (gb = 0; gb < 8; gb++) begin : g_bank
            logic [3:0] rp_cnt_q;
            assign pre_hit[gb] = pre_cmd
                                 && (all_bank_flag || cmd_bank == 3'(gb));
            assign rp_busy[gb] = (rp_cnt_q != 4'h0);
            always_ff @(posedge i_ck or negedge lrst_n_q) begin
                if (!lrst_n_q) begin
                    rp_cnt_q <= 4'h0;
                    open_q[gb] <= 1'b0;
                end else begin
                    if (pre_hit[gb]) begin
                        rp_cnt_q <= all_bank_flag ? 4'(lbp_pkg::RP_AB_CYC)
                                    : 4'(lbp_pkg::RP_PB_CYC);        // R20
                        open_q[gb] <= 1'b0;
                    end else begin
                        if (rp_busy[gb]) begin
                            rp_cnt_q <= rp_cnt_q - 4'h1;
                        end
                        if (act_cmd && cmd_bank == 3'(gb)) begin
                            open_q[gb] <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate
    // Protocol error detection
    logic                        err_now;
    logic                        err_q;
    always_comb begin
        err_now = 1'b0;
        if (rd_cmd) begin
            err_now = !open_q[cmd_bank]
                || (burst_q == lbp_pkg::B_WR && gap7 < wtr_min)      // R10
                || (burst_q == lbp_pkg::B_RD && intr_bad);           // R2 R3
        end
        if (wr_cmd) begin
            err_now = !open_q[cmd_bank]
                || (burst_q == lbp_pkg::B_RD && gap7 < rtw_min)      // R1 R4
                || (burst_q == lbp_pkg::B_WR && intr_bad);           // R11 R12
        end
        if (bst_cmd) begin
            err_now = !active || bst_done_q || gap_q[0] || ap_q;     // R14 R17
        end
        if (pre_cmd && burst_q == lbp_pkg::B_RD
            && (all_bank_flag || cmd_bank == last_bank_q)) begin
            err_now = gap7 < {3'h0, half_q} || gap7 < rtp_min;       // R21 R22
        end
        if (act_cmd) begin
            err_now = open_q[cmd_bank] || rp_busy[cmd_bank];         // R20
        end
    end

    always_ff @(posedge i_ck or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            err_q <= 1'b0;
        end else if (err_now) begin
            err_q <= 1'b1;                                           // R24
        end
    end
    // Read output and write capture schedules
    logic [lbp_pkg::SCHED_W-1:0] rd_sched_q;
    logic [lbp_pkg::SCHED_W-1:0] wr_sched_q;
    logic [lbp_pkg::SCHED_W-1:0] wr_start_q;
    logic [lbp_pkg::SCHED_W-1:0] bl_mask;
    logic [lbp_pkg::SCHED_W-1:0] rd_keep;
    logic [lbp_pkg::SCHED_W-1:0] wr_keep;
    logic                        cut_rd;
    logic                        cut_wr;
    assign bl_mask = ~({lbp_pkg::SCHED_W{1'b1}} << bl_half);
    assign rd_keep = ~({lbp_pkg::SCHED_W{1'b1}} << (lbp_pkg::RL - 1));
    assign wr_keep = ~({lbp_pkg::SCHED_W{1'b1}} << lbp_pkg::WL);
    assign cut_rd  = rd_cmd || (bst_cmd && burst_q == lbp_pkg::B_RD);
    assign cut_wr  = wr_cmd || (bst_cmd && burst_q == lbp_pkg::B_WR);
    always_ff @(posedge i_ck or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            rd_sched_q <= '0;
            o_rd_en    <= 1'b0;
        end else begin
            o_rd_en <= rd_sched_q[0];
            if (cut_rd) begin
                rd_sched_q <= ((rd_sched_q >> 1) & rd_keep)          // R6 R16
                    | ({lbp_pkg::SCHED_W{rd_cmd}}
                       & (bl_mask << (lbp_pkg::RL - 1)));            // R2
            end else begin
                rd_sched_q <= rd_sched_q >> 1;
            end
        end
    end

    always_ff @(posedge i_ck or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            wr_sched_q <= '0;
            wr_start_q <= '0;
        end else if (cut_wr) begin
            wr_sched_q <= ((wr_sched_q >> 1) & wr_keep)              // R6 R16
                | ({lbp_pkg::SCHED_W{wr_cmd}}
                   & (bl_mask << lbp_pkg::WL));                      // R8 R9
            wr_start_q <= ((wr_start_q >> 1) & wr_keep)
                | (lbp_pkg::SCHED_W'(wr_cmd) << lbp_pkg::WL);
        end else begin
            wr_sched_q <= wr_sched_q >> 1;
            wr_start_q <= wr_start_q >> 1;
        end
    end
    // Write address pipeline, one entry per latency cycle
    lbp_pkg::lbp_addr_s          addr_pipe_q [lbp_pkg::PIPE_D];
    genvar gp;
    generate
        for (gp = 0; gp < lbp_pkg::PIPE_D; gp++) begin : g_pipe
            always_ff @(posedge i_ck or negedge lrst_n_q) begin
                if (!lrst_n_q) begin
                    addr_pipe_q[gp] <= '0;
                end else if (gp == lbp_pkg::PIPE_D - 1) begin
                    addr_pipe_q[gp] <= cmd_addr;
                end else begin
                    addr_pipe_q[gp] <= addr_pipe_q[gp+1];
                end
            end
        end
    endgenerate
    // Write pair capture and toggle toward the system clock
    lbp_pkg::lbp_addr_s          cap_addr;
    lbp_pkg::lbp_addr_s          next_addr_q;
    lbp_pkg::lbp_wr_pair_s       xfer_q;
    logic                        cap_en;
    logic                        xfer_tgl_q;
    assign cap_en   = wr_sched_q[0];                                 // R9
    assign cap_addr = wr_start_q[0] ? addr_pipe_q[0] : next_addr_q;
    always_ff @(posedge i_ck or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
            next_addr_q <= '0;
            xfer_q      <= '0;
            xfer_tgl_q  <= 1'b0;
        end else if (cap_en) begin
            next_addr_q.bank <= cap_addr.bank;
            next_addr_q.col  <= cap_addr.col + 12'h2;
            xfer_q.addr      <= cap_addr;
            xfer_q.data      <= {i_dq_f, i_dq_r};
            xfer_q.be        <= ~{i_dm_f, i_dm_r};                   // R18
            xfer_tgl_q       <= ~xfer_tgl_q;
        end
    end
    // System clock side: synchronisers and pair hand-off
    logic [2:0]                  tgl_s_q;
    logic [1:0]                  err_s_q;
    logic [7:0]                  open_s1_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tgl_s_q     <= 3'h0;
            err_s_q     <= 2'h0;
            open_s1_q   <= 8'h00;
            o_bank_open <= 8'h00;
            o_proto_err <= 1'b0;
        end else begin
            tgl_s_q     <= {tgl_s_q[1:0], xfer_tgl_q};
            err_s_q     <= {err_s_q[0], err_q};
            open_s1_q   <= open_q;
            o_bank_open <= open_s1_q;
            o_proto_err <= err_s_q[1];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wr_valid <= 1'b0;
            o_wr_pair  <= '0;
        end else begin
            o_wr_valid <= tgl_s_q[2] ^ tgl_s_q[1];
            if (tgl_s_q[2] ^ tgl_s_q[1]) begin
                o_wr_pair <= xfer_q;
            end
        end
    end
    // Checks on the link clock
    default clocking cb_link @(posedge i_ck);
    endclocking
    default disable iff (!lrst_n_q);
    sequence s_bst_rd;
        bst_cmd && burst_q == lbp_pkg::B_RD && active;
    endsequence
    sequence s_quiet3;
        !rd_cmd [*3];
    endsequence
    property p_rd_start;
        rd_cmd |-> ##A_RL1 o_rd_en;
    endproperty
    a_rd_start: assert property (p_rd_start) // R2
        else $error("read output did not start after RL");
    property p_bst_rd_end;
        s_bst_rd ##1 s_quiet3 |=> !o_rd_en;
    endproperty
    a_bst_rd_end: assert property (p_bst_rd_end) // R16
        else $error("read output not ended by terminate");
    property p_wr_cap;
        wr_cmd |-> ##A_WL1 (cap_en && wr_start_q[0]);
    endproperty
    a_wr_cap: assert property (p_wr_cap) // R8
        else $error("write capture not started after WL");
    property p_mask;
        cap_en |=> xfer_q.be == ~$past({i_dm_f, i_dm_r});
    endproperty
    a_mask: assert property (p_mask) // R18
        else $error("byte enables do not follow write mask");
    property p_bst_len;
        (bst_cmd && active && !bst_done_q && !rd_cmd && !wr_cmd)
            |=> half_q == $past(gap_q[3:0]) && bst_done_q;
    endproperty
    a_bst_len: assert property (p_bst_len) // R15
        else $error("effective length not twice terminate gap");
    property p_bst_twice;
        bst_cmd && bst_done_q |=> err_q;
    endproperty
    a_bst_twice: assert property (p_bst_twice) // R17
        else $error("second terminate not flagged");
    property p_pre_all;
        pre_cmd && all_bank_flag |=> open_q == 8'h00
            && g_bank[0].rp_cnt_q == 4'(lbp_pkg::RP_AB_CYC);
    endproperty
    a_pre_all: assert property (p_pre_all) // R19
        else $error("all-bank precharge did not close banks");
    property p_pre_one;
        pre_cmd && !all_bank_flag |=> !open_q[$past(cmd_bank)];
    endproperty
    a_pre_one: assert property (p_pre_one) // R19
        else $error("single-bank precharge did not close bank");
    property p_closed_rd;
        (rd_cmd || wr_cmd) && !open_q[cmd_bank] |=> err_q;
    endproperty
    a_closed_rd: assert property (p_closed_rd) // R24
        else $error("access to closed bank not flagged");
endmodule : lbp_burst_precharge

`default_nettype wire

// ===== core/lbp_pkg.sv
// Purpose: Shared constants and types of the burst and precharge logic
// Assumes: Command clock from the memory controller, 80 ns period in bench
// Notes:   Times are kept in ps and turned into clock counts here
`default_nettype none

package lbp_pkg;

    // Latencies and burst length coding
    localparam int RL         = 3;
    localparam int WL         = 1;
    localparam int TCCD       = 2;
    localparam int SCHED_W    = RL + 8;
    localparam int PIPE_D     = WL + 1;
    localparam logic [1:0] BL_SEL_4 = 2'h0;

    // Analog times in ps and derived command clock counts
    localparam int TCK_LINK_PS  = 80000;
    localparam int T_DQSCK_PS   = 5500;
    localparam int T_WTR_PS     = 7500;
    localparam int T_RTP_PS     = 7500;
    localparam int T_RPPB_PS    = 18000;
    localparam int T_RPAB_PS    = 21000;
    localparam int RU_DQSCK  = (T_DQSCK_PS + TCK_LINK_PS - 1) / TCK_LINK_PS;
    localparam int RU_WTR    = (T_WTR_PS + TCK_LINK_PS - 1) / TCK_LINK_PS;
    localparam int RU_RTP    = (T_RTP_PS + TCK_LINK_PS - 1) / TCK_LINK_PS;
    localparam int RP_PB_CYC = (T_RPPB_PS + TCK_LINK_PS - 1) / TCK_LINK_PS;
    localparam int RP_AB_CYC = (T_RPAB_PS + TCK_LINK_PS - 1) / TCK_LINK_PS;
    localparam int RTP_EXTRA = ((RU_RTP > 2) ? RU_RTP : 2) - 2;

    // Field positions on the command/address bus
    localparam int CA_SEL0   = 0;
    localparam int CA_SEL1   = 1;
    localparam int CA_SEL2   = 2;
    localparam int CA_SEL3   = 3;
    localparam int CA_ALLBK  = 4;
    localparam int CA_BANK_L = 7;
    localparam int CA_AP     = 0;

    // Reset values
    localparam logic [5:0] GAP_RST = 6'h3f;

    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_RD   = 2'b01,
        B_WR   = 2'b10
    } lbp_burst_e;

    typedef struct packed {
        logic [2:0]  bank;
        logic [11:0] col;
    } lbp_addr_s;

    typedef struct packed {
        lbp_addr_s   addr;
        logic [63:0] data;
        logic [7:0]  be;
    } lbp_wr_pair_s;

endpackage : lbp_pkg

`default_nettype wire

// ===== verification/lbp_ctrl_model.sv
// Purpose: Memory controller model driving command, address and write data
// Assumes: Free running command clock of 80 ns, phase unrelated to i_clk
// Notes:   Released or deselected lines show the inverse of their last value
`default_nettype none

module lbp_ctrl_model (
    // Link outputs
    output logic        o_ck,
    output logic        o_cs_n,
    output logic [9:0]  o_ca_r,
    output logic [9:0]  o_ca_f,
    output logic [31:0] o_dq_r,
    output logic [31:0] o_dq_f,
    output logic [3:0]  o_dm_r,
    output logic [3:0]  o_dm_f
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_ck   = 1'b0;
        o_cs_n = 1'b1;
        o_ca_r = 10'h000;
        o_ca_f = 10'h000;
        o_dq_r = 32'h0000_0000;
        o_dq_f = 32'h0000_0000;
        o_dm_r = 4'h0;
        o_dm_f = 4'h0;
        #13;
        forever #40 o_ck = ~o_ck;
    end

    // One link cycle: op 4'hf means no command
    task automatic cyc(input logic [3:0] op, input logic [2:0] bank,
                       input logic [11:0] col, input logic ab,
                       input logic dv, input logic [63:0] dq,
                       input logic [7:0] dm);
        @(posedge o_ck);
        #2;
        o_cs_n = (op == 4'hf);
        if (op != 4'hf) begin
            o_ca_r = {bank, col[2:1], ab, op};
            o_ca_f = {col[11:3], 1'b0};
        end else begin
            o_ca_r = ~o_ca_r;
            o_ca_f = ~o_ca_f;
        end
        if (dv) begin
            {o_dq_f, o_dq_r} = dq;
            {o_dm_f, o_dm_r} = dm;
        end else begin
            {o_dq_f, o_dq_r} = ~{o_dq_f, o_dq_r};
            {o_dm_f, o_dm_r} = ~{o_dm_f, o_dm_r};
        end
    endtask : cyc

endmodule : lbp_ctrl_model

`default_nettype wire

// ===== verification/testbench.sv
// Purpose: Self-checking bench of the burst and precharge logic
// Assumes: Controller model supplies the link clock and commands
// Notes:   Read window is timed in link edges, write pairs on i_clk
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [3:0] OP_ACT = 4'h2;
    localparam logic [3:0] OP_RD  = 4'h5;
    localparam logic [3:0] OP_WR  = 4'h1;
    localparam logic [3:0] OP_BST = 4'h3;
    localparam logic [3:0] OP_PRE = 4'hb;
    localparam logic [3:0] OP_NOP = 4'hf;

    logic                  i_clk = 1'b0;
    logic                  i_rst_n = 1'b0;
    logic [1:0]            i_bl_sel = 2'h0;
    logic                  ck, cs_n;
    logic [9:0]            ca_r, ca_f;
    logic [31:0]           dq_r, dq_f;
    logic [3:0]            dm_r, dm_f;
    logic                  o_rd_en, o_wr_valid, o_proto_err;
    logic [7:0]            o_bank_open;
    lbp_pkg::lbp_wr_pair_s o_wr_pair;
    lbp_pkg::lbp_wr_pair_s wq[$];
    int                    fails = 0, n_tests = 0;
    int                    ck_n = 0, rd_cnt = 0, rd_first = 0;

    always #4 i_clk = ~i_clk;

    lbp_ctrl_model ctl (.o_ck(ck), .o_cs_n(cs_n), .o_ca_r(ca_r),
        .o_ca_f(ca_f), .o_dq_r(dq_r), .o_dq_f(dq_f), .o_dm_r(dm_r),
        .o_dm_f(dm_f));

    lbp_burst_precharge uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ck(ck),
        .i_cs_n(cs_n), .i_ca_r(ca_r), .i_ca_f(ca_f), .i_dq_r(dq_r),
        .i_dq_f(dq_f), .i_dm_r(dm_r), .i_dm_f(dm_f), .i_bl_sel(i_bl_sel),
        .o_rd_en(o_rd_en), .o_wr_valid(o_wr_valid), .o_wr_pair(o_wr_pair),
        .o_proto_err(o_proto_err), .o_bank_open(o_bank_open));

    always @(posedge ck) begin
        if (o_rd_en === 1'b1) begin
            if (rd_cnt == 0) rd_first = ck_n;
            rd_cnt++;
        end
        ck_n++;
    end

    always @(posedge i_clk) begin
        if (o_wr_valid === 1'b1) wq.push_back(o_wr_pair);
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_pair(input lbp_pkg::lbp_wr_pair_s exp,
                            input lbp_pkg::lbp_wr_pair_s got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error wr_pair expected %h seen %h", exp, got);
        end
    endtask : chk_pair

    task automatic cmd(input logic [3:0] op, input logic [2:0] bank,
                       input logic ab);
        ctl.cyc(op, bank, 12'h0a4, ab, 1'b0, 64'h0, 8'h00);
    endtask : cmd

    task automatic nop(input int n);
        repeat (n) cmd(OP_NOP, 3'h0, 1'b0);
    endtask : nop

    function automatic logic [63:0] pat(input int i);
        return 64'h0123_4567_89ab_cdef + 64'(i) * 64'h1111_0000_2222_0303;
    endfunction : pat

    // BL4 write, or BL8 write cut by terminate at gap 2
    task automatic do_write(input logic bst);
        lbp_pkg::lbp_wr_pair_s e;
        i_bl_sel = {1'b0, bst};
        wq.delete();
        cmd(OP_WR, 3'h2, 1'b0);
        nop(1);
        for (int i = 0; i < (bst ? 4 : 2); i++) begin
            ctl.cyc((bst && i == 0) ? OP_BST : OP_NOP, 3'h0, 12'h000, 1'b0,
                    1'b1, pat(i), 8'h05 << i);
        end
        nop(8);
        chk("wr_count", 32'd2, 32'(wq.size()));
        for (int i = 0; i < 2 && i < wq.size(); i++) begin
            e.addr.bank = 3'h2;
            e.addr.col  = 12'h0a4 + 12'(2 * i);
            e.data      = pat(i);
            e.be        = ~(8'h05 << i);
            chk_pair(e, wq[i]);
        end
    endtask : do_write

    // Read bank 2, then op2 after gap clocks; check read window
    task automatic do_read(input logic [1:0] bl, input logic [3:0] op2,
                           input int gap, input int exp_cnt);
        int e0;
        i_bl_sel = bl;
        rd_cnt = 0;
        cmd(OP_RD, 3'h2, 1'b0);
        e0 = ck_n;
        nop(gap - 1);
        cmd(op2, 3'h5, 1'b0);
        nop(20);
        chk("rd_first", 32'(e0 + lbp_pkg::RL + 1), 32'(rd_first));
        chk("rd_cnt", 32'(exp_cnt), 32'(rd_cnt));
    endtask : do_read

    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #100us;
        fails++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge i_clk);
        repeat (2) @(posedge ck);
        chk("reset_outs", 32'h0,
            {o_rd_en, o_wr_valid, o_proto_err, o_bank_open});
        #2 i_rst_n = 1'b1;
        repeat (3) @(posedge ck);
        cmd(OP_ACT, 3'h2, 1'b0);
        cmd(OP_ACT, 3'h5, 1'b0);
        nop(4);
        chk("bank_open", 32'h24, 32'(o_bank_open));
        do_write(1'b0);
        do_write(1'b1);
        do_read(2'h0, OP_RD, 2, 4);
        do_read(2'h1, OP_RD, 2, 6);
        do_read(2'h1, OP_BST, 2, 2);
        do_read(2'h2, OP_RD, 8, 16);
        cmd(OP_PRE, 3'h2, 1'b0);
        nop(4);
        chk("bank_open_pb", 32'h20, 32'(o_bank_open));
        cmd(OP_PRE, 3'h0, 1'b1);
        nop(4);
        chk("bank_open_ab", 32'h00, 32'(o_bank_open));
        chk("proto_err_ok", 32'h0, 32'(o_proto_err));
        cmd(OP_RD, 3'h3, 1'b0);
        nop(4);
        chk("proto_err_bad", 32'h1, 32'(o_proto_err));
        wrap_up();
    end

endmodule : testbench

`default_nettype wire
